// ---- src/ddl_pkg.sv ----
// constants and word layout for the dual DAC serial loader
//
// What this block does
// - shift 16 bits, MSB first, on falling clock
// - transfer on select rise; ignore clocks when high
// - decode program bits to latch A, B, buffer
// - power-up clears both output latches to zero
// - pattern 0X00 loads latch B and buffer
// - speed bit of latest word sets speed
// - pattern 0d01 loads buffer only, outputs unchanged
// - pattern 1X0X loads A, copies buffer to B
// - counting mode locks input after 16 clocks
// - select may be frame sync; its rise after the count is ignored
// - early select rise also ends the write
package ddl_pkg;

    // ---------------------------------------------------------------
    // word geometry and counts
    // ---------------------------------------------------------------
    localparam int          WORD_BITS  = 16;
    localparam int          DATA_BITS  = 12;
    localparam int          CNT_BITS   = 5;
    localparam logic [4:0]  LOCK_COUNT = 5'h10;   // clocks per word in counting mode
    localparam logic [4:0]  CNT_RESET  = 5'h00;
    localparam logic [11:0] DAC_RESET  = 12'h000; // zero code after power-up
    localparam logic        SPEED_RESET = 1'h0;   // slow settling after power-up
    localparam logic        PDN_RESET   = 1'h0;   // powered up after power-up

    // received word: four program bits then twelve data bits
    typedef struct packed {
        logic                 latch_a_select_bit;
        logic                 speed_select_bit;
        logic                 powerdown_bit;
        logic                 buffer_only_bit;
        logic [DATA_BITS-1:0] data;
    } ddl_word_t;

endpackage : ddl_pkg

// ---- src/ddl_loader.sv ----
// serial input logic and output latches of the dual DAC loader
`timescale 1ns/10ps
`default_nettype none

module ddl_loader
    import ddl_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        ser_clk,     // serial clock from host, link domain
    input  wire logic        cs_n,        // chip select, may be host frame sync
    input  wire logic        ser_din,
    input  wire logic        count_mode,  // 1: count 16 clocks then lock
    output logic [11:0]      dac_a_q,
    output logic [11:0]      dac_b_q,
    output logic [11:0]      buffer_q,
    output logic             fast_mode_q,
    output logic             powerdown_q,
    output logic             update_q     // one-cycle pulse per latch transfer
);

    // ---------------------------------------------------------------
    // link domain: serial input register
    // ---------------------------------------------------------------
    logic [WORD_BITS-1:0] serial_input_register;
    logic [CNT_BITS-1:0]  bit_cnt_q;
    logic                 cmode_l1_q;
    logic                 cmode_l2_q;
    logic                 lock_l;

    // strap sync into the link domain; only meaningful once clocks run
    always_ff @(negedge ser_clk)
    begin
        cmode_l1_q <= count_mode;
        cmode_l2_q <= cmode_l1_q;
    end

    assign lock_l = cmode_l2_q && (bit_cnt_q == LOCK_COUNT);

    // counter held clear by select high
    // the clock may stop between frames, so select itself ends the frame
    always_ff @(negedge ser_clk or posedge cs_n)
    begin
        if (cs_n)
            bit_cnt_q <= CNT_RESET;
        else if (bit_cnt_q != LOCK_COUNT)
            bit_cnt_q <= bit_cnt_q + 5'h01;
    end

    // msb first shift on the falling edge
    // in counting mode, no shifting once the count is reached
    always_ff @(negedge ser_clk)
    begin
        if (!cs_n && !lock_l)
            serial_input_register <= {serial_input_register[WORD_BITS-2:0], ser_din};
    end

    // shift order check
    // case equality: the register has no reset, so the first frame still carries
    // undefined bits from power-up that shift through unchanged
    a_shift_msb_first: assert property (@(negedge ser_clk) disable iff (cs_n)
        !lock_l |=> serial_input_register[WORD_BITS-1:1]
                    === $past(serial_input_register[WORD_BITS-2:0]))
        else $error("serial register did not shift msb first");

    a_lock_holds_word: assert property (@(negedge ser_clk) disable iff (cs_n)
        lock_l |=> $stable(serial_input_register))
        else $error("serial register moved after lock");

    // ---------------------------------------------------------------
    // core domain: synchronisers and edge detection
    // ---------------------------------------------------------------
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic dn_s1_q, dn_s2_q, dn_s3_q;
    logic cm_s1_q, cm_s2_q;
    logic done_seen_q;
    logic cs_rise, cs_fall, done_rise, xfer;
    ddl_word_t word;

    // two-flop sync of select, lock level and mode strap
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cs_s1_q <= 1'h1;
            cs_s2_q <= 1'h1;
            cs_s3_q <= 1'h1;
            dn_s1_q <= 1'h0;
            dn_s2_q <= 1'h0;
            dn_s3_q <= 1'h0;
            cm_s1_q <= 1'h0;
            cm_s2_q <= 1'h0;
        end
        else
        begin
            cs_s1_q <= cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            dn_s1_q <= lock_l;
            dn_s2_q <= dn_s1_q;
            dn_s3_q <= dn_s2_q;
            cm_s1_q <= count_mode;
            cm_s2_q <= cm_s1_q;
        end
    end

    assign cs_rise   = cs_s2_q && !cs_s3_q;
    assign cs_fall   = !cs_s2_q && cs_s3_q;
    assign done_rise = dn_s2_q && !dn_s3_q;

    // in counting mode, whichever comes first, select rise or sixteenth clock
    // select rise ends the write even before the count
    assign xfer = (cm_s2_q && done_rise) || (cs_rise && !done_seen_q && !done_rise);

    // after the count, a late frame-sync level is ignored until next fall
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            done_seen_q <= 1'h0;
        else if (cm_s2_q && done_rise)
            done_seen_q <= 1'h1;
        else if (cs_fall)
            done_seen_q <= 1'h0;
    end

    // word is stable here: select high or lock stops all shifting
    assign word = ddl_word_t'(serial_input_register);

    // ---------------------------------------------------------------
    // latch transfers
    // ---------------------------------------------------------------
    // reset clears latches to zero code
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            dac_a_q  <= DAC_RESET;
            dac_b_q  <= DAC_RESET;
            buffer_q <= DAC_RESET;
        end
        else if (xfer)
        begin
            // latch A written, B takes old buffer contents together
            if (word.latch_a_select_bit)
            begin
                dac_a_q <= word.data;
                dac_b_q <= buffer_q;
            end
            // latch B and buffer both loaded
            else if (!word.buffer_only_bit)
            begin
                dac_b_q  <= word.data;
                buffer_q <= word.data;
            end
            else
                buffer_q <= word.data;
        end
    end

    // speed and power-down follow the latest word
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            fast_mode_q <= SPEED_RESET;
            powerdown_q <= PDN_RESET;
            update_q    <= 1'h0;
        end
        else
        begin
            update_q <= xfer;
            if (xfer)
            begin
                fast_mode_q <= word.speed_select_bit;
                powerdown_q <= word.powerdown_bit;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_reset_zero: assert property (@(posedge core_clk)
        !rst_n |=> dac_a_q == DAC_RESET && dac_b_q == DAC_RESET)
        else $error("latches not zero after reset");

    a_latch_a_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
        xfer && word.latch_a_select_bit
        |=> dac_a_q == $past(word.data) && dac_b_q == $past(buffer_q) && update_q)
        else $error("latch A write or buffer copy wrong");

    a_latch_b_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        xfer && !word.latch_a_select_bit && !word.buffer_only_bit
        |=> dac_b_q == $past(word.data) && buffer_q == dac_b_q && $stable(dac_a_q))
        else $error("latch B load wrong");

    a_buffer_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        xfer && !word.latch_a_select_bit && word.buffer_only_bit
        |=> $stable(dac_a_q) && $stable(dac_b_q) && buffer_q == $past(word.data))
        else $error("buffer-only write touched outputs");

    a_speed_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
        xfer |=> fast_mode_q == $past(word.speed_select_bit)
                 && powerdown_q == $past(word.powerdown_bit))
        else $error("speed or power-down not from latest word");

    a_idle_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !xfer |=> $stable(dac_a_q) && $stable(dac_b_q) && $stable(buffer_q))
        else $error("latches changed without a transfer");

    a_count_update: assert property (@(posedge core_clk) disable iff (!rst_n)
        cm_s2_q && dn_s1_q && !dn_s2_q ##1 1 |-> xfer ##1 update_q)
        else $error("no transfer at end of count");

    a_early_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
        cs_rise && !done_seen_q |-> xfer)
        else $error("select rise did not transfer");

    a_late_sync_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
        done_seen_q && !done_rise |-> !xfer)
        else $error("second transfer in one frame");

endmodule : ddl_loader

`default_nettype wire

// ---- testbench/ddl_host_model.sv ----
// host serial port model that drives the loader link
`timescale 1ns/10ps
`default_nettype none

module ddl_host_model (
    output var logic ser_clk,
    output var logic cs_n,
    output var logic ser_din
);
    // link idles: clock low, select high
    // select rises once early so the link counter, which has no reset of its
    // own, is cleared by a real edge instead of a time-zero ordering race
    initial
    begin
        ser_clk = 1'b0;
        cs_n    = 1'b0;
        ser_din = 1'b0;
        #5 cs_n = 1'b1;
    end

    // ---------------------------------------------------------------
    // one frame of n bits, optional byte split, then clocks with select high
    // ---------------------------------------------------------------
    task automatic send(input logic [31:0] w, input int n, input bit split, input int post);
        int i;
        cs_n = 1'b0;
        #200;
        for (i = n - 1; i >= 0; i--)
        begin
            ser_din = w[i];
            #40 ser_clk = 1'b1;
            #80 ser_clk = 1'b0;
            #40;
            if (split && i == 8)
                #400;
        end
        // select may stay low past the count
        #40 cs_n = 1'b1;
        ser_din = ~ser_din; // released line shows no stale bit
        #200;
        for (i = 0; i < post; i++)
        begin
            ser_din = ~ser_din;
            #80 ser_clk = 1'b1;
            #80 ser_clk = 1'b0;
        end
    endtask : send
endmodule : ddl_host_model

`default_nettype wire

// ---- testbench/ddl_loader_tb.sv ----
// self-checking bench for the dual DAC serial loader
`timescale 1ns/10ps
`default_nettype none

module ddl_loader_tb;
    import ddl_pkg::*;
    logic        core_clk, rst_n, count_mode, ser_clk, cs_n, ser_din;
    logic        fast_mode_q, powerdown_q, update_q;
    logic [11:0] dac_a_q, dac_b_q, buffer_q;
    int          bad_count = 0, comparisons = 0, ups = 0, ups0;

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    ddl_loader ddl_loader_inst (.core_clk(core_clk), .rst_n(rst_n), .ser_clk(ser_clk),
        .cs_n(cs_n), .ser_din(ser_din), .count_mode(count_mode), .dac_a_q(dac_a_q),
        .dac_b_q(dac_b_q), .buffer_q(buffer_q), .fast_mode_q(fast_mode_q),
        .powerdown_q(powerdown_q), .update_q(update_q));
    ddl_host_model ddl_host_model_inst (.ser_clk(ser_clk), .cs_n(cs_n), .ser_din(ser_din));

    // count transfer pulses so a missing or doubled transfer shows
    always @(posedge core_clk) if (update_q === 1'b1) ups <= ups + 1;

    // ---------------------------------------------------------------
    // shared helpers
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic st(input logic [11:0] a, b, bf, input logic f, p);
        chk("dac_a", a, dac_a_q);
        chk("dac_b", b, dac_b_q);
        chk("buffer", bf, buffer_q);
        chk("fast", {11'h000, f}, {11'h000, fast_mode_q});
        chk("powerdown", {11'h000, p}, {11'h000, powerdown_q});
    endtask : st

    // one frame, then exactly one transfer must have been seen
    task automatic frame(input logic [31:0] w, input int n, input bit split, input int post);
        ups0 = ups;
        ddl_host_model_inst.send(w, n, split, post);
        repeat (12) @(posedge core_clk);
        chk("transfers", 12'h001, 12'(ups - ups0));
    endtask : frame

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_words();
        st(12'h000, 12'h000, 12'h000, 1'b0, 1'b0);
        frame(32'h4FFF, 16, 1'b0, 0);
        st(12'h000, 12'hFFF, 12'hFFF, 1'b1, 1'b0);
        frame(32'h5123, 16, 1'b1, 0);
        st(12'h000, 12'hFFF, 12'h123, 1'b1, 1'b0);
        frame(32'hD800, 16, 1'b0, 0);
        st(12'h800, 12'h123, 12'h123, 1'b1, 1'b0);
        frame(32'h27AB, 16, 1'b0, 0);
        st(12'h800, 12'h7AB, 12'h7AB, 1'b0, 1'b1);
        frame(32'hF0ABC, 20, 1'b0, 5);
        st(12'h800, 12'hABC, 12'hABC, 1'b0, 1'b0);
    endtask : t_words

    task automatic t_count();
        @(posedge core_clk);
        count_mode <= 1'b1;
        repeat (8) @(posedge core_clk);
        frame(32'h0DEFF, 20, 1'b0, 0);
        st(12'h800, 12'hDEF, 12'hDEF, 1'b0, 1'b0);
        // short word: the low nibble of the locked word becomes the program bits
        frame(32'h00B, 12, 1'b0, 3);
        st(12'h00B, 12'hDEF, 12'hDEF, 1'b1, 1'b1);
        frame(32'h0321, 16, 1'b0, 0);
        st(12'h00B, 12'h321, 12'h321, 1'b0, 1'b0);
    endtask : t_count

    task automatic wrap_up();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // main sequence
    initial
    begin
        rst_n      = 1'b0;
        count_mode = 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_words();
        t_count();
        wrap_up();
    end

    // watchdog cuts a hang short
    initial
    begin
        #2000000;
        bad_count++;
        $display("mismatch watchdog expected finish seen timeout");
        wrap_up();
    end
endmodule : ddl_loader_tb

`default_nettype wire
